// >>> design/hsq_defs.svh
`ifndef HSQ_DEFS_SVH
`define HSQ_DEFS_SVH

// Switch select codes used by the step table
`define HSQ_SW_NEG   2'h0
`define HSQ_SW_POS   2'h1
`define HSQ_SW_HOME  2'h2

// Bit positions inside the synchronised pin vector
`define HSQ_PIN_NEG  0
`define HSQ_PIN_POS  1
`define HSQ_PIN_HOME 2
`define HSQ_PIN_IDX  3
`define HSQ_PIN_NUM  4

// Method codes with special limit handling
`define HSQ_METH_FIRST 3'h1
`define HSQ_METH_NEGL  3'h1
`define HSQ_METH_POSL  3'h2
`define HSQ_METH_SW_LO 3'h3
`define HSQ_METH_SW_HI 3'h6
`define HSQ_METH_REV   3'h7

// Reset values
`define HSQ_POS_RST  32'h0000_0000
`define HSQ_IDX_RST  2'h0

`endif

// >>> design/hsq_homing_sequencer.sv
// Function
// [R1] M1, negative limit off: fast negative to limit on, stop, slow positive.
// [R2] M1: after negative limit turns off, keep positive, home on next index.
// [R3] M1, negative limit on: slow positive, after it turns off home on index.
// [R4] M2, positive limit off: fast positive to on, stop, slow negative, index.
// [R5] M2, positive limit on: slow negative to its off edge, then index.
// [R6] M3, home off: fast positive to on, stop, slow negative off edge, index.
// [R7] M3, home on: fast negative off, back fast on, slow negative off, index.
// [R8] M3-M6: any limit active aborts homing with alarm, no reversal.
// [R9] M4, home off: fast on, fast back off, slow positive on edge, index.
// [R10] M4, home on: fast negative off edge, slow positive on edge, index.
// [R11] M5, home off: fast negative on edge, slow positive off edge, index.
// [R12] M5, home on: fast positive off, back fast on, slow positive off.
// [R13] M6, home off: fast negative on, back fast off, slow negative on.
// [R14] M6, home on: fast positive off edge, slow negative on edge, index.
// [R15] M7 positive side: fast to positive limit, reverse, then as home-on.
// [R16] M7 negative side: fast positive on edge, slow negative off, index.
// [R17] M7 home on: fast off, fast back on with overshoot, slow off, index.
// [R18] M7: first positive limit reverses; negative or second one alarms.
// [R19] Index capture stops motion, latches home, done held until restart.
// [R20] Each decelerate step waits for motion stopped before next command.
`timescale 1ns/1ps
`include "hsq_defs.svh"

module hsq_homing_sequencer #(
  parameter int POS_W = 32
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  input  wire logic             i_start,
  input  wire logic [2:0]       i_method,
  input  wire logic             i_negative_limit_switch,
  input  wire logic             i_positive_limit_switch,
  input  wire logic             i_home_position_switch,
  input  wire logic             i_index_pulse,
  input  wire logic             i_motion_stopped,
  input  wire logic [POS_W-1:0] i_position,
  output hsq_pkg::hsq_cmd_t     o_cmd,
  output logic                  o_busy,
  output logic                  o_home_done,
  output logic                  o_alarm,
  output logic [POS_W-1:0]      o_home_pos
);
  import hsq_pkg::*;

  localparam logic DP  = 1'b1;
  localparam logic DN  = 1'b0;
  localparam logic HI  = 1'b1;
  localparam logic LO  = 1'b0;
  localparam logic ON  = 1'b1;
  localparam logic OFF = 1'b0;
  localparam logic FIN = 1'b1;
  localparam logic MID = 1'b0;
  localparam logic [1:0] SWN = `HSQ_SW_NEG;
  localparam logic [1:0] SWP = `HSQ_SW_POS;
  localparam logic [1:0] SWH = `HSQ_SW_HOME;

  // Pins are asynchronous; edges are taken from stage two against stage three
  logic [`HSQ_PIN_NUM-1:0] pin_raw;
  logic [`HSQ_PIN_NUM-1:0] sync1_reg;
  logic [`HSQ_PIN_NUM-1:0] sync2_reg;
  logic [`HSQ_PIN_NUM-1:0] prev_reg;

  assign pin_raw = {i_index_pulse, i_home_position_switch,
                    i_positive_limit_switch, i_negative_limit_switch};

  for (genvar g = 0; g < `HSQ_PIN_NUM; g++) begin : g_sync
    always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
        prev_reg[g]  <= 1'b0;
      end else begin
        sync1_reg[g] <= pin_raw[g];
        sync2_reg[g] <= sync1_reg[g];
        prev_reg[g]  <= sync2_reg[g];
      end
    end
  end

  // Move table keyed by method, switch state at start and step number
  function automatic hsq_step_t step_of(input logic [2:0] m,
                                        input logic       a,
                                        input logic [1:0] i);
    hsq_step_t s;
    s = '{DN, LO, SWH, OFF, FIN};
    case ({m, a, i})
      {3'h1, 1'b0, 2'h0}: s = '{DN, HI, SWN, ON,  MID}; // see [R1]
      {3'h1, 1'b0, 2'h1}: s = '{DP, LO, SWN, OFF, FIN}; // see [R2]
      {3'h1, 1'b1, 2'h0}: s = '{DP, LO, SWN, OFF, FIN}; // see [R3]
      {3'h2, 1'b0, 2'h0}: s = '{DP, HI, SWP, ON,  MID}; // see [R4]
      {3'h2, 1'b0, 2'h1}: s = '{DN, LO, SWP, OFF, FIN}; // see [R4]
      {3'h2, 1'b1, 2'h0}: s = '{DN, LO, SWP, OFF, FIN}; // see [R5]
      {3'h3, 1'b0, 2'h0}: s = '{DP, HI, SWH, ON,  MID}; // see [R6]
      {3'h3, 1'b0, 2'h1}: s = '{DN, LO, SWH, OFF, FIN}; // see [R6]
      {3'h3, 1'b1, 2'h0}: s = '{DN, HI, SWH, OFF, MID}; // see [R7]
      {3'h3, 1'b1, 2'h1}: s = '{DP, HI, SWH, ON,  MID}; // see [R7]
      {3'h3, 1'b1, 2'h2}: s = '{DN, LO, SWH, OFF, FIN}; // see [R7]
      {3'h4, 1'b0, 2'h0}: s = '{DP, HI, SWH, ON,  MID}; // see [R9]
      {3'h4, 1'b0, 2'h1}: s = '{DN, HI, SWH, OFF, MID}; // see [R9]
      {3'h4, 1'b0, 2'h2}: s = '{DP, LO, SWH, ON,  FIN}; // see [R9]
      {3'h4, 1'b1, 2'h0}: s = '{DN, HI, SWH, OFF, MID}; // see [R10]
      {3'h4, 1'b1, 2'h1}: s = '{DP, LO, SWH, ON,  FIN}; // see [R10]
      {3'h5, 1'b0, 2'h0}: s = '{DN, HI, SWH, ON,  MID}; // see [R11]
      {3'h5, 1'b0, 2'h1}: s = '{DP, LO, SWH, OFF, FIN}; // see [R11]
      {3'h5, 1'b1, 2'h0}: s = '{DP, HI, SWH, OFF, MID}; // see [R12]
      {3'h5, 1'b1, 2'h1}: s = '{DN, HI, SWH, ON,  MID}; // see [R12]
      {3'h5, 1'b1, 2'h2}: s = '{DP, LO, SWH, OFF, FIN}; // see [R12]
      {3'h6, 1'b0, 2'h0}: s = '{DN, HI, SWH, ON,  MID}; // see [R13]
      {3'h6, 1'b0, 2'h1}: s = '{DP, HI, SWH, OFF, MID}; // see [R13]
      {3'h6, 1'b0, 2'h2}: s = '{DN, LO, SWH, ON,  FIN}; // see [R13]
      {3'h6, 1'b1, 2'h0}: s = '{DP, HI, SWH, OFF, MID}; // see [R14]
      {3'h6, 1'b1, 2'h1}: s = '{DN, LO, SWH, ON,  FIN}; // see [R14]
      {3'h7, 1'b0, 2'h0}: s = '{DP, HI, SWH, ON,  MID}; // see [R16]
      {3'h7, 1'b0, 2'h1}: s = '{DN, LO, SWH, OFF, FIN}; // see [R16]
      // Overshoot past a narrow zone is harmless: the slow move needs on, off
      {3'h7, 1'b1, 2'h0}: s = '{DN, HI, SWH, OFF, MID}; // see [R17]
      {3'h7, 1'b1, 2'h1}: s = '{DP, HI, SWH, ON,  MID}; // see [R17]
      {3'h7, 1'b1, 2'h2}: s = '{DN, LO, SWH, OFF, FIN}; // see [R17]
      default:            s = '{DN, LO, SWH, OFF, FIN};
    endcase
    return s;
  endfunction : step_of

  hsq_state_t       state_reg, state_next;
  logic [2:0]       meth_reg, meth_next;
  logic             act_reg, act_next;
  logic             rev_reg, rev_next;
  logic [1:0]       idx_reg, idx_next;
  logic [POS_W-1:0] home_reg, home_next;

  hsq_step_t step;
  logic      sw_now;
  logic      sw_prev;
  logic      edge_hit;
  logic      idx_hit;
  logic      neg_on;
  logic      pos_on;
  logic      pos_rise;
  logic      is_m7;
  logic      is_m36;
  logic      moving;
  logic      can_start;
  logic      meth_ok;
  logic      start_act;
  logic      alarm_hit;
  logic      rev_hit;

  assign step      = step_of(meth_reg, act_reg, idx_reg);
  assign sw_now    = sync2_reg[step.sw];
  assign sw_prev   = prev_reg[step.sw];
  assign edge_hit  = step.rise ? (sw_now & ~sw_prev) : (~sw_now & sw_prev);
  assign idx_hit   = sync2_reg[`HSQ_PIN_IDX] & ~prev_reg[`HSQ_PIN_IDX];
  assign neg_on    = sync2_reg[`HSQ_PIN_NEG];
  assign pos_on    = sync2_reg[`HSQ_PIN_POS];
  assign pos_rise  = pos_on & ~prev_reg[`HSQ_PIN_POS];
  assign is_m7     = (meth_reg == `HSQ_METH_REV);
  assign is_m36    = (meth_reg >= `HSQ_METH_SW_LO) &&
                     (meth_reg <= `HSQ_METH_SW_HI);
  assign moving    = (state_reg == HSQ_MOVE) || (state_reg == HSQ_DECEL) ||
                     (state_reg == HSQ_SEEK);
  assign can_start = (state_reg == HSQ_IDLE) || (state_reg == HSQ_DONE) ||
                     (state_reg == HSQ_ALARM);
  assign meth_ok   = (i_method >= `HSQ_METH_FIRST);
  assign start_act = (i_method == `HSQ_METH_NEGL) ? neg_on :
                     (i_method == `HSQ_METH_POSL) ? pos_on :
                     sync2_reg[`HSQ_PIN_HOME];

  // Methods 1 and 2 only guard the far limit, which is never their target
  assign alarm_hit = moving && (
      (is_m36 && (neg_on || pos_on)) ||                          // see [R8]
      (is_m7 && (neg_on || (pos_rise && rev_reg))) ||            // see [R18]
      ((meth_reg == `HSQ_METH_NEGL) && pos_on) ||
      ((meth_reg == `HSQ_METH_POSL) && neg_on));
  assign rev_hit   = is_m7 && !rev_reg && pos_rise && step.dir_pos &&
                     (state_reg == HSQ_MOVE);                    // see [R18]

  always_comb begin
    state_next = state_reg;
    meth_next  = meth_reg;
    act_next   = act_reg;
    rev_next   = rev_reg;
    idx_next   = idx_reg;
    home_next  = home_reg;
    unique case (state_reg)
      HSQ_IDLE, HSQ_DONE, HSQ_ALARM: begin
        if (i_start) begin
          meth_next  = i_method;
          act_next   = start_act;
          rev_next   = 1'b0;
          idx_next   = `HSQ_IDX_RST;
          state_next = meth_ok ? HSQ_MOVE : HSQ_ALARM;
        end
      end
      HSQ_MOVE: begin
        if (alarm_hit) begin
          state_next = HSQ_ALARM;
        end else if (rev_hit) begin
          // Restart as if the switch had been on at start
          rev_next   = 1'b1;                                     // see [R15]
          act_next   = 1'b1;
          idx_next   = `HSQ_IDX_RST;
          state_next = HSQ_DECEL;
        end else if (edge_hit && step.last) begin
          state_next = HSQ_SEEK;                                 // see [R2]
        end else if (edge_hit) begin
          idx_next   = idx_reg + 2'h1;
          state_next = HSQ_DECEL;
        end
      end
      HSQ_DECEL: begin
        if (alarm_hit) begin
          state_next = HSQ_ALARM;
        end else if (i_motion_stopped) begin
          state_next = HSQ_MOVE;                                 // see [R20]
        end
      end
      HSQ_SEEK: begin
        if (alarm_hit) begin
          state_next = HSQ_ALARM;
        end else if (idx_hit) begin
          home_next  = i_position;                               // see [R19]
          state_next = HSQ_DONE;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= HSQ_IDLE;
      meth_reg  <= `HSQ_METH_FIRST;
      act_reg   <= 1'b0;
      rev_reg   <= 1'b0;
      idx_reg   <= `HSQ_IDX_RST;
      home_reg  <= POS_W'(`HSQ_POS_RST);
    end else begin
      state_reg <= state_next;
      meth_reg  <= meth_next;
      act_reg   <= act_next;
      rev_reg   <= rev_next;
      idx_reg   <= idx_next;
      home_reg  <= home_next;
    end
  end

  // Run drops in decel, done and alarm, so the axis stops in each
  assign o_cmd.run     = (state_reg == HSQ_MOVE) ||
                         (state_reg == HSQ_SEEK);                // see [R20]
  assign o_cmd.dir_pos = step.dir_pos;
  assign o_cmd.fast    = step.fast;
  assign o_busy        = moving;
  assign o_home_done   = (state_reg == HSQ_DONE);                // see [R19]
  assign o_alarm       = (state_reg == HSQ_ALARM);
  assign o_home_pos    = home_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  property p_m1_free;
    can_start && i_start && i_method == 3'h1 && !neg_on
      |=> o_cmd.run && !o_cmd.dir_pos && o_cmd.fast;
  endproperty
  a_m1_free: assert property (p_m1_free) // see [R1]
    else $error("method 1 did not start fast negative");

  property p_m1_on;
    can_start && i_start && i_method == 3'h1 && neg_on
      |=> o_cmd.run && o_cmd.dir_pos && !o_cmd.fast;
  endproperty
  a_m1_on: assert property (p_m1_on) // see [R3]
    else $error("method 1 did not start slow positive");

  property p_m2_dir;
    can_start && i_start && i_method == 3'h2
      |=> o_cmd.dir_pos == !$past(pos_on) && o_cmd.fast == !$past(pos_on);
  endproperty
  a_m2_dir: assert property (p_m2_dir) // see [R4] [R5]
    else $error("method 2 start move wrong");

  property p_final_seek;
    state_reg == HSQ_MOVE && edge_hit && step.last && !alarm_hit && !rev_hit
      |=> state_reg == HSQ_SEEK && o_cmd.run &&
          o_cmd.dir_pos == $past(step.dir_pos);
  endproperty
  a_final_seek: assert property (p_final_seek) // see [R2] [R6] [R10]
    else $error("final edge did not start index search");

  property p_mid_stop;
    state_reg == HSQ_MOVE && edge_hit && !step.last && !alarm_hit &&
      !rev_hit |=> !o_cmd.run && idx_reg == $past(idx_reg) + 2'h1;
  endproperty
  a_mid_stop: assert property (p_mid_stop) // see [R7] [R9] [R12] [R13]
    else $error("intermediate edge did not stop and advance");

  property p_decel_wait;
    state_reg == HSQ_DECEL && !i_motion_stopped ##1 !alarm_hit
      |-> !o_cmd.run;
  endproperty
  a_decel_wait: assert property (p_decel_wait) // see [R20]
    else $error("moved again before stop reported");

  property p_lim_alarm;
    moving && is_m36 && (neg_on || pos_on)
      |=> o_alarm && !o_cmd.run [*2];
  endproperty
  a_lim_alarm: assert property (p_lim_alarm) // see [R8]
    else $error("limit in methods 3 to 6 did not alarm");

  property p_rev;
    rev_hit && !alarm_hit |=> state_reg == HSQ_DECEL && rev_reg &&
      idx_reg == 2'h0 && !o_cmd.dir_pos && o_cmd.fast;
  endproperty
  a_rev: assert property (p_rev) // see [R18] [R15]
    else $error("first positive limit did not reverse");

  property p_m7_alarm;
    moving && is_m7 && (neg_on || (pos_rise && rev_reg)) |=> o_alarm;
  endproperty
  a_m7_alarm: assert property (p_m7_alarm) // see [R18]
    else $error("method 7 limit did not alarm");

  property p_home;
    state_reg == HSQ_SEEK && idx_hit && !alarm_hit |=>
      o_home_done && !o_cmd.run && o_home_pos == $past(i_position)
      ##1 (o_home_done || $past(i_start));
  endproperty
  a_home: assert property (p_home) // see [R19] [R11] [R14] [R16] [R17]
    else $error("index capture did not complete homing");

  c_done_m1:  cover property (o_home_done && meth_reg == 3'h1);
  c_done_m4:  cover property (o_home_done && meth_reg == 3'h4);
  c_rev_done: cover property (o_home_done && is_m7 && rev_reg);
  c_alarm:    cover property (o_alarm && is_m36);

endmodule : hsq_homing_sequencer

// >>> design/hsq_pkg.sv
package hsq_pkg;

  // Motion command towards the trajectory generator
  typedef struct packed {
    logic run;
    logic dir_pos;
    logic fast;
  } hsq_cmd_t;

  // One move of a homing sequence
  typedef struct packed {
    logic       dir_pos;
    logic       fast;
    logic [1:0] sw;
    logic       rise;
    logic       last;
  } hsq_step_t;

  typedef enum logic [5:0] {
    HSQ_IDLE  = 6'b000001,
    HSQ_MOVE  = 6'b000010,
    HSQ_DECEL = 6'b000100,
    HSQ_SEEK  = 6'b001000,
    HSQ_DONE  = 6'b010000,
    HSQ_ALARM = 6'b100000
  } hsq_state_t;

endpackage : hsq_pkg

// >>> verification/hsq_axis_model.sv
`timescale 1ns/1ps
module hsq_axis_model #(
  parameter int NEG_EDGE = -2000,
  parameter int POS_EDGE = 2000,
  parameter int HOME_LO  = 0,
  parameter int HOME_HI  = 200
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rstn,
  input  wire hsq_pkg::hsq_cmd_t  i_cmd,
  input  wire logic               i_load,
  input  wire logic signed [31:0] i_load_pos,
  output logic                    o_neg,
  output logic                    o_pos,
  output logic                    o_home,
  output logic                    o_index,
  output logic                    o_stopped,
  output logic [31:0]             o_position,
  output logic [7:0]              o_viol
);
  import hsq_pkg::*;
  logic signed [31:0] pos_reg;
  logic signed [31:0] step_reg;
  logic [2:0]         dcnt_reg;
  logic               run_d_reg;
  wire signed [31:0]  step_next = i_cmd.fast ?
                        (i_cmd.dir_pos ? 32'sd8 : -32'sd8) :
                        (i_cmd.dir_pos ? 32'sd1 : -32'sd1);
  // Coasting after run drops keeps the axis moving, as a real stop does
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_reg   <= '0;
      step_reg  <= '0;
      dcnt_reg  <= '0;
      run_d_reg <= 1'b0;
      o_viol    <= '0;
    end else if (i_load) begin
      pos_reg  <= i_load_pos;
      dcnt_reg <= '0;
    end else begin
      run_d_reg <= i_cmd.run;
      if (i_cmd.run && !run_d_reg && dcnt_reg != 3'h0) begin
        o_viol <= o_viol + 8'h01;
      end
      if (i_cmd.run) begin
        step_reg <= step_next;
        pos_reg  <= pos_reg + step_next;
        dcnt_reg <= 3'h4;
      end else if (dcnt_reg != 3'h0) begin
        pos_reg  <= pos_reg + step_reg;
        dcnt_reg <= dcnt_reg - 3'h1;
      end
    end
  end
  assign o_neg      = pos_reg < NEG_EDGE;
  assign o_pos      = pos_reg > POS_EDGE;
  assign o_home     = pos_reg >= HOME_LO && pos_reg < HOME_HI;
  assign o_index    = pos_reg[5:0] >= 6'h20 && pos_reg[5:0] < 6'h24;
  assign o_stopped  = dcnt_reg == 3'h0;
  assign o_position = pos_reg;
endmodule : hsq_axis_model

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  import hsq_pkg::*;
  `define HSQ_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("unexpected %s expected %0h seen %0h", nm, e, g); \
    end end
  typedef struct { logic alarm; int idx; } hsq_exp_t;
  logic               i_mclk;
  logic               i_rstn;
  logic               i_start;
  logic [2:0]         i_method;
  logic               i_load;
  logic signed [31:0] i_load_pos;
  logic               neg, pos, home, index, stopped, busy, done, alarm;
  logic [31:0]        position, home_pos;
  logic [7:0]         viol;
  hsq_cmd_t           cmd;
  logic               res_d;
  int                 n_mismatch, num_checks, n_seen, cycles, seed;
  hsq_exp_t           expq[$];

  hsq_homing_sequencer hsq_homing_sequencer_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(i_start),
    .i_method(i_method), .i_negative_limit_switch(neg),
    .i_positive_limit_switch(pos), .i_home_position_switch(home),
    .i_index_pulse(index), .i_motion_stopped(stopped),
    .i_position(position), .o_cmd(cmd), .o_busy(busy),
    .o_home_done(done), .o_alarm(alarm), .o_home_pos(home_pos));
  hsq_axis_model hsq_axis_model_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_cmd(cmd), .i_load(i_load),
    .i_load_pos(i_load_pos), .o_neg(neg), .o_pos(pos), .o_home(home),
    .o_index(index), .o_stopped(stopped), .o_position(position),
    .o_viol(viol));

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task end_sim;
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Index rises at offset 32 going up and at offset 35 going down
  function int next_idx(int edge_at, bit up);
    int p;
    p = edge_at;
    while ((p & 63) != (up ? 32 : 35)) p += up ? 1 : -1;
    return p;
  endfunction : next_idx

  function logic near(logic [31:0] hp, int idx);
    logic signed [32:0] d;
    d = $signed({hp[31], hp}) - idx;
    return d <= 8 && d >= -8;
  endfunction : near

  task run_case(int m, int start, bit alm, int edge_at, bit up);
    hsq_exp_t e;
    int       w;
    @(posedge i_mclk);
    i_load     <= 1'b1;
    i_load_pos <= start + ($random(seed) & 15);
    @(posedge i_mclk);
    i_load <= 1'b0;
    repeat (4 + ($random(seed) & 3)) @(posedge i_mclk);
    e.alarm = alm;
    e.idx   = next_idx(edge_at, up);
    expq.push_back(e);
    w = n_seen;
    i_start  <= 1'b1;
    i_method <= m[2:0];
    @(posedge i_mclk);
    i_start <= 1'b0;
    for (int k = 0; k < 5000 && n_seen == w; k++) @(posedge i_mclk);
    `HSQ_CHK("result_seen", w + 1, n_seen)
    repeat (3) @(posedge i_mclk);
    `HSQ_CHK("done_hold", ~alm, done)
    `HSQ_CHK("decel_wait", 8'h00, viol)
  endtask : run_case

  // Outputs are read before this edge's updates land
  always @(posedge i_mclk) begin
    hsq_exp_t e;
    // A taken start closes the old result, so alarm after alarm still counts
    res_d <= (done | alarm) & ~i_start;
    if ((done | alarm) && !res_d) begin
      n_seen++;
      if (expq.size() == 0) begin
        `HSQ_CHK("queue_empty", 1'b0, 1'b1)
      end else begin
        e = expq.pop_front();
        `HSQ_CHK("alarm", e.alarm, alarm)
        `HSQ_CHK("busy", 1'b0, busy)
        `HSQ_CHK("run", 1'b0, cmd.run)
        if (!e.alarm)
          `HSQ_CHK("home_pos", 1'b1, near(home_pos, e.idx))
      end
    end
  end

  // Whole run is some 20 scenarios of a few hundred cycles each
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    seed       = 32'h1eca;
    i_rstn     = 1'b0;
    i_start    = 1'b0;
    i_method   = 3'h0;
    i_load     = 1'b0;
    i_load_pos = '0;
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_mclk);
    run_case(1, 500, 0, -2000, 1);
    run_case(1, -2100, 0, -2000, 1);
    run_case(2, 500, 0, 2000, 0);
    run_case(2, 2100, 0, 2000, 0);
    run_case(3, -500, 0, -1, 0);
    run_case(3, 100, 0, -1, 0);
    run_case(3, 500, 1, 0, 1);
    run_case(5, -500, 1, 0, 1);
    run_case(4, -500, 0, 0, 1);
    run_case(4, 100, 0, 0, 1);
    run_case(5, 500, 0, 200, 1);
    run_case(5, 100, 0, 200, 1);
    run_case(6, 500, 0, 199, 0);
    run_case(6, 100, 0, 199, 0);
    run_case(7, 500, 0, -1, 0);
    run_case(7, -500, 0, -1, 0);
    run_case(7, 100, 0, -1, 0);
    run_case(7, -2100, 1, 0, 1);
    run_case(0, 500, 1, 0, 1);
    end_sim();
  end
endmodule : tb
